// ---- scr_top.sv ----
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`include "scr_defs.svh"

module scr_top (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        rxd_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic             irq_o,
	output logic             rx_irq_o
);

	// ==========================================================
	// declarations
	logic [3:0]             presc_q, presc_d;
	logic [6:0]             div_q, div_d;
	logic [6:0]             div_lim;
	logic                   presc_tick;
	logic                   tick16;
	logic [2:0]             baud_sel_q, baud_sel_d;
	logic                   rie_q, rie_d;
	logic [`SCR_EV_N-1:0]   imask_q, imask_d;
	scr_pkg::scr_rx_state_t st_q, st_d;
	logic [3:0]             cnt_q, cnt_d;
	logic [2:0]             bit_q, bit_d;
	logic [7:0]             shift_q, shift_d;
	logic [2:0]             smp_q, smp_d;
	logic                   noise_q, noise_d;
	logic                   maj;
	logic                   mixed;
	logic                   rx_done;
	logic                   rx_bad_stop;
	logic                   rx_noise;
	logic                   receive_data_full_flag_q, receive_data_full_flag_d;
	logic                   or_q, or_d;
	logic                   nf_q, nf_d;
	logic                   fe_q, fe_d;
	logic [7:0]             data_q, data_d;
	logic [3:0]             arm_q, arm_d;
	logic [3:0]             clr;
	logic                   full_now;
	logic                   load;
	logic                   ovr;
	logic [`SCR_EV_N-1:0]   ev;
	logic [`SCR_EV_N-1:0]   ist_q, ist_d;
	logic                   aw_got_q, aw_got_d;
	logic [7:0]             aw_addr_q, aw_addr_d;
	logic                   w_got_q, w_got_d;
	logic [31:0]            w_data_q, w_data_d;
	logic [3:0]             w_strb_q, w_strb_d;
	logic                   bvalid_q, bvalid_d;
	logic [1:0]             bresp_q, bresp_d;
	logic                   do_wr;
	logic                   wr_ctrl;
	logic                   wr_istat;
	logic                   wr_imask;
	logic                   rvalid_q, rvalid_d;
	logic [31:0]            rdata_q, rdata_d;
	logic [1:0]             rresp_q, rresp_d;
	logic                   ar_hs;
	logic                   rd_status;
	logic                   rd_data;
	logic [7:0]             status;

	// ==========================================================
	// prescaler and baud divider
	always_comb begin
		presc_tick = (presc_q == `SCR_PRESC_MAX);
		presc_d    = presc_tick ? 4'h0 : presc_q + 4'h1;
		div_lim    = 7'((8'h01 << baud_sel_q) - 8'h01);
		// at or above the limit, so a lowered select does not wait for a wrap
		tick16     = presc_tick && (div_q >= div_lim);
		if (!presc_tick) begin
			div_d = div_q;
		end else if (tick16) begin
			div_d = 7'h00;
		end else begin
			div_d = div_q + 7'h01;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			presc_q <= 4'h0;
			div_q   <= 7'h00;
		end else if (ce_i) begin
			presc_q <= presc_d;
			div_q   <= div_d;
		end
	end

	// ==========================================================
	// receiver: 16x oversampling, majority of three samples
	always_comb begin
		maj         = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
		mixed       = (|smp_q) && !(&smp_q);
		st_d        = st_q;
		cnt_d       = cnt_q;
		bit_d       = bit_q;
		shift_d     = shift_q;
		smp_d       = smp_q;
		noise_d     = noise_q;
		rx_done     = 1'b0;
		rx_bad_stop = !maj;
		rx_noise    = noise_q | mixed;
		if (tick16) begin
			if (st_q != scr_pkg::scr_rx_idle) begin
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == `SCR_SMP_A) begin
					smp_d[0] = rxd_i;
				end
				if (cnt_q == `SCR_SMP_B) begin
					smp_d[1] = rxd_i;
				end
				if (cnt_q == `SCR_SMP_C) begin
					smp_d[2] = rxd_i;
				end
			end
			unique case (st_q)
				scr_pkg::scr_rx_idle: begin
					if (!rxd_i) begin
						st_d    = scr_pkg::scr_rx_start;
						cnt_d   = 4'h0;
						noise_d = 1'b0;
					end
				end
				scr_pkg::scr_rx_start: begin
					if (cnt_q == `SCR_SMP_END) begin
						// false start goes back to idle
						st_d    = maj ? scr_pkg::scr_rx_idle : scr_pkg::scr_rx_data;
						bit_d   = 3'h0;
						noise_d = noise_q | mixed;
					end
				end
				scr_pkg::scr_rx_data: begin
					if (cnt_q == `SCR_SMP_END) begin
						shift_d = {maj, shift_q[7:1]};
						noise_d = noise_q | mixed;
						bit_d   = bit_q + 3'h1;
						if (bit_q == `SCR_LAST_BIT) begin
							st_d = scr_pkg::scr_rx_stop;
						end
					end
				end
				scr_pkg::scr_rx_stop: begin
					if (cnt_q == `SCR_SMP_END) begin
						rx_done = 1'b1;
						st_d    = scr_pkg::scr_rx_idle;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_q    <= scr_pkg::scr_rx_idle;
			cnt_q   <= 4'h0;
			bit_q   <= 3'h0;
			shift_q <= 8'h00;
			smp_q   <= 3'h7;
			noise_q <= 1'b0;
		end else if (ce_i) begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			bit_q   <= bit_d;
			shift_q <= shift_d;
			smp_q   <= smp_d;
			noise_q <= noise_d;
		end
	end

	// ==========================================================
	// receive flags and data register
	always_comb begin
		// arm holds {receive_data_full_flag, or, nf, fe} as seen by the last status read
		if (rd_status) begin
			arm_d = {receive_data_full_flag_q, or_q, nf_q, fe_q};
		end else if (rd_data) begin
			arm_d = 4'h0;
		end else begin
			arm_d = arm_q;
		end
		clr      = rd_data ? arm_q : 4'h0;
		full_now = receive_data_full_flag_q && !clr[3];
		ovr      = rx_done && full_now;
		load     = rx_done && !full_now;
		// set wins over clear in the same cycle
		receive_data_full_flag_d   = load | (receive_data_full_flag_q & !clr[3]);
		or_d     = ovr | (or_q & !clr[2]);
		nf_d     = (load & rx_noise) | (nf_q & !clr[1]);
		fe_d     = (load & rx_bad_stop) | (fe_q & !clr[0]);
		data_d   = load ? shift_q : data_q;
		ev       = '0;
		ev[`SCR_EV_RECEIVE_DATA_FULL_FLAG] = load;
		ev[`SCR_EV_OR]   = ovr;
		ev[`SCR_EV_NF]   = load & rx_noise;
		ev[`SCR_EV_FE]   = load & rx_bad_stop;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			receive_data_full_flag_q <= 1'b0;
			or_q   <= 1'b0;
			nf_q   <= 1'b0;
			fe_q   <= 1'b0;
			data_q <= 8'h00;
			arm_q  <= 4'h0;
		end else if (ce_i) begin
			receive_data_full_flag_q <= receive_data_full_flag_d;
			or_q   <= or_d;
			nf_q   <= nf_d;
			fe_q   <= fe_d;
			data_q <= data_d;
			arm_q  <= arm_d;
		end
	end

	// ==========================================================
	// interrupt status, write one to clear
	generate
		for (genvar i = 0; i < `SCR_EV_N; i++) begin : g_ist
			always_comb begin
				ist_d[i] = ev[i] | (ist_q[i] & !(wr_istat & w_data_q[i]));
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ist_q <= '0;
		end else if (ce_i) begin
			ist_q <= ist_d;
		end
	end

	assign irq_o    = |(ist_q & imask_q);
	assign rx_irq_o = rie_q & (or_q | receive_data_full_flag_q);

	// ==========================================================
	// control registers
	always_comb begin
		rie_d      = wr_ctrl ? w_data_q[`SCR_CT_RIE] : rie_q;
		baud_sel_d = wr_ctrl ? w_data_q[`SCR_CT_BAUD_HI:`SCR_CT_BAUD_LO] : baud_sel_q;
		imask_d    = wr_imask ? w_data_q[`SCR_EV_N-1:0] : imask_q;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rie_q   <= 1'b0;
			imask_q <= '0;
		end else if (ce_i) begin
			rie_q   <= rie_d;
			imask_q <= imask_d;
		end
	end

	// no reset on purpose
	always_ff @(posedge sys_clk_i) begin
		if (ce_i) begin
			baud_sel_q <= baud_sel_d;
		end
	end

	// ==========================================================
	// axi4-lite write channel
	assign s_axi_awready_o = ce_i && !aw_got_q && !bvalid_q;
	assign s_axi_wready_o  = ce_i && !w_got_q && !bvalid_q;
	assign s_axi_bvalid_o  = bvalid_q;
	assign s_axi_bresp_o   = bresp_q;

	always_comb begin
		do_wr     = aw_got_q && w_got_q && !bvalid_q;
		wr_ctrl   = do_wr && (aw_addr_q == `SCR_OFF_CTRL) && w_strb_q[0];
		wr_istat  = do_wr && (aw_addr_q == `SCR_OFF_ISTAT) && w_strb_q[0];
		wr_imask  = do_wr && (aw_addr_q == `SCR_OFF_IMASK) && w_strb_q[0];
		aw_got_d  = aw_got_q;
		aw_addr_d = aw_addr_q;
		w_got_d   = w_got_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_got_d  = 1'b1;
			aw_addr_d = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_got_d  = 1'b1;
			w_data_d = s_axi_wdata_i;
			w_strb_d = s_axi_wstrb_i;
		end
		if (do_wr) begin
			aw_got_d = 1'b0;
			w_got_d  = 1'b0;
			bvalid_d = 1'b1;
			if ((aw_addr_q == `SCR_OFF_CTRL) || (aw_addr_q == `SCR_OFF_ISTAT) ||
			    (aw_addr_q == `SCR_OFF_IMASK)) begin
				bresp_d = `SCR_RESP_OKAY;
			end else begin
				bresp_d = `SCR_RESP_SLVERR;
			end
		end else if (bvalid_q && s_axi_bready_i) begin
			bvalid_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			aw_got_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_got_q   <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `SCR_RESP_OKAY;
		end else if (ce_i) begin
			aw_got_q  <= aw_got_d;
			aw_addr_q <= aw_addr_d;
			w_got_q   <= w_got_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
		end
	end

	// ==========================================================
	// axi4-lite read channel
	assign s_axi_arready_o = ce_i && !rvalid_q;
	assign s_axi_rvalid_o  = rvalid_q;
	assign s_axi_rdata_o   = rdata_q;
	assign s_axi_rresp_o   = rresp_q;

	always_comb begin
		ar_hs     = s_axi_arvalid_i && s_axi_arready_o;
		rd_status = ar_hs && (s_axi_araddr_i == `SCR_OFF_STATUS);
		rd_data   = ar_hs && (s_axi_araddr_i == `SCR_OFF_DATA);
		status    = 8'h00;
		status[`SCR_ST_RECEIVE_DATA_FULL_FLAG] = receive_data_full_flag_q;
		status[`SCR_ST_OR]   = or_q;
		status[`SCR_ST_NF]   = nf_q;
		status[`SCR_ST_FE]   = fe_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (ar_hs) begin
			rvalid_d = 1'b1;
			rresp_d  = `SCR_RESP_OKAY;
			rdata_d  = 32'h0000_0000;
			unique case (s_axi_araddr_i)
				`SCR_OFF_STATUS: rdata_d[7:0] = status;
				`SCR_OFF_DATA:   rdata_d[7:0] = data_q;
				`SCR_OFF_CTRL: begin
					rdata_d[`SCR_CT_RIE] = rie_q;
					rdata_d[`SCR_CT_BAUD_HI:`SCR_CT_BAUD_LO] = baud_sel_q;
				end
				`SCR_OFF_ISTAT:  rdata_d[`SCR_EV_N-1:0] = ist_q;
				`SCR_OFF_IMASK:  rdata_d[`SCR_EV_N-1:0] = imask_q;
				default:         rresp_d = `SCR_RESP_SLVERR;
			endcase
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `SCR_RESP_OKAY;
		end else if (ce_i) begin
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end

endmodule

// ---- scr_defs.svh ----
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// ==========================================================
// register byte offsets
`define SCR_OFF_STATUS  8'h00
`define SCR_OFF_DATA    8'h04
`define SCR_OFF_CTRL    8'h08
`define SCR_OFF_ISTAT   8'h0C
`define SCR_OFF_IMASK   8'h10

// ==========================================================
// field positions
`define SCR_ST_RECEIVE_DATA_FULL_FLAG     5
`define SCR_ST_OR       3
`define SCR_ST_NF       2
`define SCR_ST_FE       1
`define SCR_CT_RIE      5
`define SCR_CT_BAUD_HI  2
`define SCR_CT_BAUD_LO  0
`define SCR_EV_RECEIVE_DATA_FULL_FLAG     0
`define SCR_EV_OR       1
`define SCR_EV_NF       2
`define SCR_EV_FE       3
`define SCR_EV_N        4

// ==========================================================
// timing counts
`define SCR_PRESC_MAX   4'hC
`define SCR_SMP_A       4'h7
`define SCR_SMP_B       4'h8
`define SCR_SMP_C       4'h9
`define SCR_SMP_END     4'hF
`define SCR_LAST_BIT    3'h7

// ==========================================================
// bus answers
`define SCR_RESP_OKAY   2'h0
`define SCR_RESP_SLVERR 2'h2

`endif

// ---- scr_pkg.sv ----
package scr_pkg;
	typedef enum logic [3:0] {
		scr_rx_idle  = 4'b0001,
		scr_rx_start = 4'b0010,
		scr_rx_data  = 4'b0100,
		scr_rx_stop  = 4'b1000
	} scr_rx_state_t;
endpackage

// ---- scr_top_asserts.sv ----
`include "scr_defs.svh"
module scr_top_asserts (
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  s_axi_araddr_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        irq_o,
	input wire logic        rx_irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// bus steps
	sequence s_rd_take;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	sequence s_wr_take;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	// ==========================================================
	// checks
	a_reset_quiet: assert property (disable iff (1'b0)
		rst_i |=> !s_axi_bvalid_o && !s_axi_rvalid_o && !irq_o && !rx_irq_o)
		else $error("outputs not quiet after reset");
	a_read_answer: assert property (s_rd_take |=> s_axi_rvalid_o)
		else $error("read answer late");
	a_read_done: assert property (
		s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("read answer not retired");
	a_read_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while answer pending");
	a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid_o)
		else $error("write answer late");
	a_write_done: assert property (
		s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write answer not retired");
	a_write_refuse: assert property (
		s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while answer pending");
	a_unmapped_read: assert property (s_rd_take ##0 (s_axi_araddr_i == 8'h14)
		|=> s_axi_rresp_o == `SCR_RESP_SLVERR && s_axi_rdata_o == 32'h0000_0000)
		else $error("unmapped read not refused");
endmodule

bind scr_top scr_top_asserts u_chk (.sys_clk_i, .rst_i, .s_axi_araddr_i, .s_axi_arvalid_i,
	.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
	.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o,
	.s_axi_bready_i, .irq_o, .rx_irq_o);

// ---- scr_line_model.sv ----
module scr_line_model (
	input  wire logic       sys_clk_i,
	input  wire logic       go_i,
	input  wire logic [7:0] data_i,
	input  wire logic       stop_i,
	input  wire logic       noisy_i,
	input  wire logic [2:0] sel_i,
	output logic            rxd_o,
	output logic            busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT_CLKS = 208;
	// glitch covers exactly one of the three samples of data bit 0 when sel_i is 0
	localparam int NZ_LO = 104;
	localparam int NZ_HI = 117;
	logic [9:0] fr;
	initial begin
		rxd_o = 1'b1;
		busy_o = 1'b0;
		forever begin
			@(posedge sys_clk_i);
			if (go_i) begin
				busy_o <= 1'b1;
				fr = {stop_i, data_i, 1'b0};
				for (int i = 0; i < 10; i++) begin
					for (int k = 0; k < (BIT_CLKS << sel_i); k++) begin
						rxd_o <= (noisy_i && i == 1 && k >= NZ_LO && k < NZ_HI) ? !fr[i] : fr[i];
						@(posedge sys_clk_i);
					end
				end
				rxd_o <= 1'b1;
				busy_o <= 1'b0;
			end
		end
	end
endmodule

// ---- tb.sv ----
`include "scr_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ST = `SCR_OFF_STATUS;
	localparam logic [7:0] DT = `SCR_OFF_DATA;
	localparam logic [7:0] CT = `SCR_OFF_CTRL;
	localparam logic [7:0] IS = `SCR_OFF_ISTAT;
	localparam logic [7:0] IM = `SCR_OFF_IMASK;
	logic        sys_clk, rst, awvalid, wvalid, arvalid, go, stop_bit, noisy;
	logic        awready, wready, bvalid, arready, rvalid, irq, rx_irq, rxd, busy;
	logic [7:0]  awaddr, araddr, tx_byte;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [2:0]  line_sel;
	int          num_errors, compares;
	scr_top dut_u (.sys_clk_i(sys_clk), .rst_i(rst), .ce_i(1'b1), .rxd_i(rxd),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1), .irq_o(irq), .rx_irq_o(rx_irq));
	scr_line_model line_u (.sys_clk_i(sys_clk), .go_i(go), .data_i(tx_byte), .stop_i(stop_bit),
		.noisy_i(noisy), .sel_i(line_sel), .rxd_o(rxd), .busy_o(busy));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value at %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic guard(inout int n);
		n++;
		if (n > 30000) begin
			num_errors++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = `SCR_RESP_OKAY);
		int   n = 0;
		logic da = 1'b0, dw = 1'b0, ta, tw;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(da && dw)) begin
			guard(n);
			@(negedge sys_clk);
			ta = !da && awready;
			tw = !dw && wready;
			@(posedge sys_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			da = da | ta;
			dw = dw | tw;
		end
		do begin guard(n); @(negedge sys_clk); end while (bvalid !== 1'b1);
		chk(32'(bresp), 32'(er));
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] want,
		input logic [1:0] er = `SCR_RESP_OKAY);
		int n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin guard(n); @(negedge sys_clk); end while (arready !== 1'b1);
		@(posedge sys_clk);
		arvalid <= 1'b0;
		do begin guard(n); @(negedge sys_clk); end while (rvalid !== 1'b1);
		chk(rdata, want);
		chk(32'(rresp), 32'(er));
		@(posedge sys_clk);
	endtask
	task automatic sd(input logic [7:0] d, input logic sb, input logic nz);
		int n = 0;
		tx_byte <= d;
		stop_bit <= sb;
		noisy <= nz;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		do begin guard(n); @(negedge sys_clk); end while (busy !== 1'b0 || n < 3);
		repeat (64) @(posedge sys_clk);
	endtask
	// ==========================================================
	// sequence
	initial begin
		num_errors = 0;
		compares = 0;
		rst = 1'b1;
		{awvalid, wvalid, arvalid, go, noisy, stop_bit} = 6'h01;
		{awaddr, araddr, tx_byte, wdata, line_sel} = '0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		wr(CT, 32'h0000_0023);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(CT, 32'h0000_0003);
		rd(ST, 32'h0000_0000);
		for (int s = 0; s < 8; s++) begin
			wr(CT, 32'(s));
			rd(CT, 32'(s));
		end
		wr(ST, 32'h0000_00FF, `SCR_RESP_SLVERR);
		rd(8'h14, 32'h0000_0000, `SCR_RESP_SLVERR);
		wr(CT, 32'h0000_0020);
		wr(IM, 32'h0000_0000);
		sd(8'hA5, 1'b1, 1'b0);
		chk({31'h0, rx_irq}, 32'h0000_0001);
		sd(8'h3C, 1'b1, 1'b0);
		rd(DT, 32'h0000_00A5);
		rd(ST, 32'h0000_0028);
		rd(DT, 32'h0000_00A5);
		rd(ST, 32'h0000_0000);
		chk({31'h0, rx_irq}, 32'h0000_0000);
		rd(IS, 32'h0000_0003);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(IM, 32'h0000_0002);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(IS, 32'h0000_0002);
		chk({31'h0, irq}, 32'h0000_0000);
		rd(IS, 32'h0000_0001);
		sd(8'h81, 1'b0, 1'b0);
		rd(ST, 32'h0000_0022);
		rd(DT, 32'h0000_0081);
		rd(ST, 32'h0000_0000);
		sd(8'h11, 1'b1, 1'b0);
		sd(8'h22, 1'b0, 1'b0);
		rd(ST, 32'h0000_0028);
		rd(DT, 32'h0000_0011);
		rd(ST, 32'h0000_0000);
		sd(8'h5A, 1'b1, 1'b1);
		rd(ST, 32'h0000_0024);
		rd(DT, 32'h0000_005A);
		rd(ST, 32'h0000_0000);
		rd(IS, 32'h0000_000F);
		for (int s = 1; s < 3; s++) begin
			wr(CT, 32'(s));
			line_sel <= 3'(s);
			sd(8'hC0 | 8'(s), 1'b1, 1'b0);
			chk({31'h0, rx_irq}, 32'h0000_0000);
			rd(ST, 32'h0000_0020);
			rd(DT, 32'h0000_00C0 | 32'(s));
		end
		tally_and_finish();
	end
endmodule
